// ### design/synth_ctrl_pkg.sv
// Types for the synthesizer control link: word type for the device end, state type for the host end.
// Assumes synth_ctrl_map.svh supplies offsets, positions and counts.
package synth_ctrl_pkg;
    typedef logic [25:0] ctrl_word_t;
    typedef enum logic [2:0] {
        HOST_IDLE  = 3'b001,
        HOST_SHIFT = 3'b010,
        HOST_LATCH = 3'b100
    } host_state_e;
endpackage

// ### design/synth_ctrl_map.svh
// Word codes, field positions, reset values and timing counts.
// Assumes inclusion by bare name from design files.
`ifndef SYNTH_CTRL_MAP_SVH
`define SYNTH_CTRL_MAP_SVH
`define WORD_LEN          26
`define CODE_MODE         2'h0
`define CODE_CAL          2'h1
`define CODE_FREQ_ONE     2'h2
`define CODE_FREQ_TWO     2'h3
`define ONE_REF_DIV_HI    3
`define ONE_REF_DIV_LO    2
`define ONE_M_HI          15
`define ONE_M_LO          10
`define ONE_A_HI          9
`define ONE_A_LO          6
`define ONE_MOD_RUN       17
`define ONE_FRAC_SEL      18
`define ONE_RSVD_HIGH     19
`define ONE_ME_HI         23
`define ONE_ME_LO         20
`define TWO_ME_HI         12
`define TWO_ME_LO         2
`define TWO_FN_HI         20
`define TWO_FN_LO         13
`define TWO_RSVD_HI       23
`define TWO_RSVD_LO       21
`define MODE_PRESCALE     23
`define CAL_ENABLE        20
`define FREQ_ONE_RESET    26'h0080000
`define CAL_RESET         26'h0000000
`define MODE_RESET        26'h0000000
`define FREQ_TWO_RESET    26'h0000000
`define HALF_PERIOD_CYC   4
// Host register offsets
`define HREG_DATA         2'h0
`define HREG_CTRL         2'h1
`define HREG_STATUS       2'h2
`endif

// ### design/synth_link_if.sv
// Three-wire serial link between host controller and synthesizer end.
// Assumes the bench joins the two modports; all wires one-way.
`timescale 1ns/10ps
interface synth_link_if;
    logic serial_clock;
    logic serial_data;
    logic load_enable;
    modport host (output serial_clock, output serial_data, output load_enable);
    modport device (input serial_clock, input serial_data, input load_enable);
endinterface

// ### design/bit_sync.sv
// Two-flop synchroniser for one level.
// Assumes d comes from outside the clock domain.
`timescale 1ns/10ps
module bit_sync (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ### design/synth_host.sv
// Host end: shifts a 26-bit word out MSB first, then pulses load.
// Assumes software port: addr, wdata, write and read strobes.
`timescale 1ns/10ps
`include "synth_ctrl_map.svh"
module synth_host
    import synth_ctrl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [1:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic      [31:0] rdata,
    synth_link_if.host       link
);
    logic [25:0] word_q;
    logic [4:0]  bit_q;
    logic [3:0]  div_q;
    logic        sclk_q;
    logic        done_q;
    host_state_e state_q;

    wire wr_data   = write_strobe && addr == `HREG_DATA;
    wire wr_ctrl   = write_strobe && addr == `HREG_CTRL;
    wire idle      = state_q == HOST_IDLE;
    wire start     = wr_ctrl && wdata[0] && idle;
    wire tick      = div_q == 4'(`HALF_PERIOD_CYC - 1);
    wire last_bit  = bit_q == 5'(`WORD_LEN - 1);
    wire [1:0] cd  = word_q[1:0];
    // Reserved bits forced so software slips cannot break the device
    wire [25:0] fixed_word =
        (cd == `CODE_FREQ_ONE) ? (word_q | (26'h1 << `ONE_RSVD_HIGH)) :
        (cd == `CODE_FREQ_TWO) ? (word_q & ~(26'h7 << `TWO_RSVD_LO)) :
        word_q;

    assign link.serial_clock = sclk_q;
    assign link.serial_data  = fixed_word[5'(`WORD_LEN - 1) - bit_q];
    assign link.load_enable  = state_q == HOST_LATCH;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            word_q  <= 26'h0;
            bit_q   <= 5'h0;
            div_q   <= 4'h0;
            sclk_q  <= 1'b0;
            done_q  <= 1'b0;
            state_q <= HOST_IDLE;
            rdata   <= 32'h0;
        end else begin
            if (wr_data && idle)
                word_q <= wdata[25:0];
            if (start)
                done_q <= 1'b0;
            div_q <= (idle || tick) ? 4'h0 : div_q + 4'h1;
            case (state_q)
                HOST_IDLE: begin
                    bit_q <= 5'h0;
                    if (start)
                        state_q <= HOST_SHIFT;
                end
                HOST_SHIFT: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            if (last_bit)
                                state_q <= HOST_LATCH;
                            else
                                bit_q <= bit_q + 5'h1;
                        end
                    end
                end
                HOST_LATCH: begin
                    if (tick) begin
                        state_q <= HOST_IDLE;
                        done_q  <= 1'b1;
                    end
                end
                default: state_q <= HOST_IDLE;
            endcase
            rdata <= !read_strobe ? 32'h0 :
                     addr == `HREG_DATA   ? {6'h0, word_q} :
                     addr == `HREG_STATUS ? {30'h0, done_q, ~idle} : 32'h0;
        end
    end
endmodule

// ### design/synth_device.sv
// Synthesizer end: serial shift register and control word decode.
// Assumes link pins are asynchronous to clock; samples them twice.
// Assumes one host drives the link and ends each frame with a load pulse.
// Behaviour
// - Code 10 updates first frequency register
// - Code 11 updates second frequency register
// - Bits 3:2 select divide 8,4,2,1
// - Bits 15:10 M, bits 9:6 A
// - In 8/9 mode bit 9 ignored
// - Bit 17 low holds modulator reset
// - Bit 18 selects integer or fractional
// - Host sets first-word bit 19 high
// - First-word bits 23:20 give extender 3:0
// - Second-word bits 12:2 give extender 14:4
// - Second-word bits 20:13 give fraction code
// - Host clears second-word bits 23:21
// - Calibration bits map to tuning-loop fields
// - Mode bit 23 picks 8/9 or 16/17
// - Calibration bit 20 enables tuning loop
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "synth_ctrl_map.svh"
module synth_device
    import synth_ctrl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    synth_link_if.device     link,
    output logic      [3:0]  ref_divide_ratio,
    output logic      [5:0]  m_count,
    output logic      [3:0]  a_count,
    output logic             prescaler_16_17,
    output logic             modulator_reset,
    output logic             fractional_mode,
    output logic      [14:0] modulus_extender,
    output logic      [7:0]  fraction_code,
    output logic      [1:0]  tuning_loop_clock_delay,
    output logic      [4:0]  tuning_loop_temp_trim,
    output logic             tuning_loop_temp_trim_en,
    output logic      [7:0]  tuning_loop_test_select,
    output logic             tuning_loop_flag_force,
    output logic             tuning_loop_flag_level,
    output logic             tuning_loop_enable,
    output logic             word_done
);
    ////////////////////////////////////////////////////////////////////////////
    // Link pins after two flops each
    logic        sclk_s;
    logic        sdata_s;
    logic        load_s;
    logic        sclk_prev_q;
    logic        load_prev_q;
    logic [25:0] shift_q;
    logic [5:0]  count_q;
    ctrl_word_t  mode_q;
    ctrl_word_t  cal_q;
    ctrl_word_t  one_q;
    ctrl_word_t  two_q;

    // Clock and data pass equal flop chains, so their skew is kept
    bit_sync u_sclk (
        .clock  (clock),
        .resetn (resetn),
        .d      (link.serial_clock),
        .q      (sclk_s)
    );
    bit_sync u_data (
        .clock  (clock),
        .resetn (resetn),
        .d      (link.serial_data),
        .q      (sdata_s)
    );
    bit_sync u_load (
        .clock  (clock),
        .resetn (resetn),
        .d      (link.load_enable),
        .q      (load_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame capture

    // Address code of a word sits in its two lowest bits
    function automatic logic code_is(input ctrl_word_t word, input logic [1:0] code);
        code_is = word[1:0] == code;
    endfunction

    wire        sclk_rise = sclk_s && !sclk_prev_q;
    wire        load_rise = load_s && !load_prev_q;
    // Short or long frames are dropped rather than half-applied
    wire        full_word = count_q == 6'(`WORD_LEN);
    // Count saturates so a runaway frame never wraps back to a full count
    wire        count_sat = count_q == 6'h3f;
    wire        latch     = load_rise && full_word;
    wire [5:0]  count_d   = load_rise               ? 6'h0          :
                            !sclk_rise              ? count_q       :
                            (full_word || count_sat) ? 6'h3f        :
                            count_q + 6'h1;
    wire [25:0] shift_d   = (sclk_rise && !load_rise) ? {shift_q[24:0], sdata_s} : shift_q;

    wire        wr_mode   = latch && code_is(shift_q, `CODE_MODE);
    wire        wr_cal    = latch && code_is(shift_q, `CODE_CAL);
    wire        wr_one    = latch && code_is(shift_q, `CODE_FREQ_ONE);
    wire        wr_two    = latch && code_is(shift_q, `CODE_FREQ_TWO);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            load_prev_q <= load_s;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 26'h0;
            count_q <= 6'h0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // One pulse per accepted word, in step with the register update
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            word_done <= 1'b0;
        else
            word_done <= latch;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bank; each word keeps its last accepted value

    // Mode word kept only for the prescaler choice
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            mode_q <= `MODE_RESET;
        else if (wr_mode)
            mode_q <= shift_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            cal_q <= `CAL_RESET;
        else if (wr_cal)
            cal_q <= shift_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            one_q <= `FREQ_ONE_RESET;
        else if (wr_one)
            one_q <= shift_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            two_q <= `FREQ_TWO_RESET;
        else if (wr_two)
            two_q <= shift_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    wire [1:0]  rdiv     = one_q[`ONE_REF_DIV_HI:`ONE_REF_DIV_LO];
    wire [3:0]  a_raw    = one_q[`ONE_A_HI:`ONE_A_LO];
    wire        p16      = mode_q[`MODE_PRESCALE];
    wire [10:0] ext_high = two_q[`TWO_ME_HI:`TWO_ME_LO];
    wire [3:0]  ext_low  = one_q[`ONE_ME_HI:`ONE_ME_LO];

    // Extender halves come from two words; a lone write leaves a mixed value
    assign ref_divide_ratio = 4'h8 >> rdiv;
    assign m_count          = one_q[`ONE_M_HI:`ONE_M_LO];
    assign prescaler_16_17  = p16;
    // Top A bit forced low in 8/9 mode so downstream never sees it
    assign a_count          = p16 ? a_raw : {1'b0, a_raw[2:0]};
    assign modulator_reset  = !one_q[`ONE_MOD_RUN];
    assign fractional_mode  = one_q[`ONE_FRAC_SEL];
    assign modulus_extender = {ext_high,
                               ext_low};
    assign fraction_code    = two_q[`TWO_FN_HI:`TWO_FN_LO];

    // Tuning-loop fields; all are expected to stay zero in normal use
    assign tuning_loop_clock_delay  = cal_q[3:2];
    assign tuning_loop_temp_trim    = cal_q[8:4];
    assign tuning_loop_temp_trim_en = cal_q[9];
    assign tuning_loop_test_select  = cal_q[17:10];
    assign tuning_loop_flag_force   = cal_q[18];
    assign tuning_loop_flag_level   = cal_q[19];
    assign tuning_loop_enable       = cal_q[`CAL_ENABLE];
endmodule

// ### test/synth_link_asserts.sv
// Checks on the three-wire link joining host and device ends.
// Assumes link pins move only just after edges of the shared clock.
`timescale 1ns/10ps
module synth_link_asserts (
    input wire logic clock,
    input wire logic resetn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_enable
);
    logic        sclk_q;
    logic [25:0] sh_q;
    logic [4:0]  cnt_q;
    wire         rise_w = serial_clock & ~sclk_q;

    // Count clears while load is high, so a load rise still sees the full count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_q <= 1'b0;
            sh_q   <= 26'h0;
            cnt_q  <= 5'h0;
        end else begin
            sclk_q <= serial_clock;
            if (rise_w) sh_q <= {sh_q[24:0], serial_data};
            cnt_q  <= load_enable ? 5'h0 : cnt_q + 5'(rise_w);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_word_count: assert property ($rose(load_enable) |-> cnt_q == 5'h1a)
        else $error("load without a full word");
    a_count_cap: assert property (rise_w |-> cnt_q < 5'h1a)
        else $error("bit shifted beyond word length");
    a_one_rsvd: assert property ($rose(load_enable) && sh_q[1:0] == 2'h2 |-> sh_q[19])
        else $error("first frequency word bit 19 low");
    a_two_rsvd: assert property ($rose(load_enable) && sh_q[1:0] == 2'h3
        |-> sh_q[23:21] == 3'h0)
        else $error("second frequency word bits 23:21 set");
    a_data_steady: assert property (serial_clock |-> $stable(serial_data))
        else $error("data moved while link clock high");
    a_high_time: assert property ($rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock)
        else $error("link clock high time wrong");
    a_low_time: assert property ($fell(serial_clock) |-> !serial_clock[*4])
        else $error("link clock low time short");
    a_load_quiet: assert property ($rose(load_enable)
        |-> !serial_clock throughout (load_enable ##[1:8] !load_enable))
        else $error("load pulse bad or clock moved");

    c_freq_one: cover property ($rose(load_enable) && sh_q[1:0] == 2'h2);
    c_freq_two: cover property ($rose(load_enable) && sh_q[1:0] == 2'h3);
    c_cal: cover property ($rose(load_enable) && sh_q[1:0] == 2'h1);
endmodule

// ### test/tb_synth_frequency_control_regs.sv
// Bench joining host end and device end over the link interface.
// Assumes bench makes clock and reset; software port driven by tasks.
`timescale 1ns/10ps
`include "synth_ctrl_map.svh"
module tb_synth_frequency_control_regs import synth_ctrl_pkg::*;;
    logic        clock = 0, resetn = 0, write_strobe = 0, read_strobe = 0;
    logic [1:0]  addr = 2'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  ref_divide_ratio, a_count;
    logic [5:0]  m_count;
    logic [14:0] modulus_extender;
    logic [7:0]  fraction_code, tuning_loop_test_select;
    logic [1:0]  tuning_loop_clock_delay;
    logic [4:0]  tuning_loop_temp_trim;
    logic        prescaler_16_17, modulator_reset, fractional_mode, word_done;
    logic        tuning_loop_temp_trim_en, tuning_loop_flag_force;
    logic        tuning_loop_flag_level, tuning_loop_enable;
    logic [58:0] exp_q[$];
    ctrl_word_t  md = `MODE_RESET, cw = `CAL_RESET, f1 = `FREQ_ONE_RESET, f2 = 0;
    integer      seed = 32'h481c, n_mismatch = 0, n_tests = 0, cyc = 0;
    wire [58:0]  seen_w = {ref_divide_ratio, m_count, a_count, prescaler_16_17,
        modulator_reset, fractional_mode, modulus_extender, fraction_code,
        tuning_loop_clock_delay, tuning_loop_temp_trim, tuning_loop_temp_trim_en,
        tuning_loop_test_select, tuning_loop_flag_force, tuning_loop_flag_level,
        tuning_loop_enable};

    synth_link_if link ();
    synth_host u_synth_host (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata), .link(link));
    synth_device u_synth_device (.clock(clock), .resetn(resetn), .link(link),
        .ref_divide_ratio(ref_divide_ratio), .m_count(m_count), .a_count(a_count),
        .prescaler_16_17(prescaler_16_17), .modulator_reset(modulator_reset),
        .fractional_mode(fractional_mode), .modulus_extender(modulus_extender),
        .fraction_code(fraction_code), .tuning_loop_clock_delay(tuning_loop_clock_delay),
        .tuning_loop_temp_trim(tuning_loop_temp_trim),
        .tuning_loop_temp_trim_en(tuning_loop_temp_trim_en),
        .tuning_loop_test_select(tuning_loop_test_select),
        .tuning_loop_flag_force(tuning_loop_flag_force),
        .tuning_loop_flag_level(tuning_loop_flag_level),
        .tuning_loop_enable(tuning_loop_enable), .word_done(word_done));
    synth_link_asserts u_synth_link_asserts (.clock(clock), .resetn(resetn),
        .serial_clock(link.serial_clock), .serial_data(link.serial_data),
        .load_enable(link.load_enable));

    ////////////////////////////////////////////////////////////////////////////
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    function automatic logic [58:0] expect_of(ctrl_word_t m, c, a, b);
        expect_of = {4'h8 >> a[3:2], a[15:10], a[9] & m[23], a[8:6], m[23],
            ~a[17], a[18], b[12:2], a[23:20], b[20:13],
            c[3:2], c[8:4], c[9], c[17:10], c[18], c[19], c[20]};
    endfunction

    task automatic check(input string what, input logic [58:0] seen, exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [1:0] a, output logic [31:0] d);
        addr <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask

    // Host forces reserved bits, so the shadow copy does the same
    task automatic send(input ctrl_word_t w);
        ctrl_word_t  v;
        logic [31:0] st;
        v = w;
        if (w[1:0] == `CODE_FREQ_ONE) v[19] = 1'b1;
        if (w[1:0] == `CODE_FREQ_TWO) v[23:21] = 3'h0;
        case (w[1:0]) 2'h0: md = v; 2'h1: cw = v; 2'h2: f1 = v; default: f2 = v; endcase
        exp_q.push_back(expect_of(md, cw, f1, f2));
        wr(`HREG_DATA, {6'h0, w});
        rd(`HREG_DATA, st);
        check("data readback", 59'(st), 59'({6'h0, w}));
        wr(`HREG_CTRL, 32'h1);
        st = 32'h0;
        for (int i = 0; i < 400 && st[1] !== 1'b1; i++) rd(`HREG_STATUS, st);
        check("host done", 59'(st[1]), 59'h1);
    endtask

    initial forever begin
        @(negedge clock);
        if (word_done === 1'b1) begin
            @(negedge clock);
            if (exp_q.size() == 0) check("unexpected word", seen_w, ~seen_w);
            else check("device outputs", seen_w, exp_q.pop_front());
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        ctrl_word_t  w;
        logic [31:0] st;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("reset outputs", seen_w, expect_of(md, cw, f1, f2));
        rd(`HREG_STATUS, st);
        check("reset status", 59'(st), 59'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            w[23] = i[0];
            w[1:0] = `CODE_MODE;
            send(w);
            w = $random(seed);
            w[9] = 1'b1;
            w[3:2] = i[1:0];
            w[1:0] = `CODE_FREQ_ONE;
            send(w);
        end
        $display("test divider and prescaler done");
        repeat (14) send($random(seed));
        repeat (20) @(posedge clock);
        check("pending words", 59'(exp_q.size()), 59'h0);
        $display("test random words done");
        conclude();
    end
endmodule
